// ===== tcd_pkg.sv
package tcd_pkg;
  // command byte layout
  localparam int unsigned CMD_W      = 8;
  localparam int unsigned START_BIT  = 7;
  localparam int unsigned CHAN_HI    = 6;
  localparam int unsigned CHAN_LO    = 4;
  localparam int unsigned MODE_BIT   = 3;
  localparam int unsigned REF_BIT    = 2;
  localparam int unsigned PD_HI      = 1;
  localparam int unsigned PD_LO      = 0;
  // receive bit indices after the start bit
  localparam logic [2:0]  RX_ACQ_IDX  = 3'h4;
  localparam logic [2:0]  RX_LAST_IDX = 3'h6;
  // result lengths and restart spacing in serial clocks
  localparam int unsigned RES12_BITS = 12;
  localparam logic [3:0]  RES12_CNT  = 4'hC;
  localparam logic [3:0]  RES8_CNT   = 4'h8;
  localparam logic [3:0]  GAP12_MIN  = 4'hF;
  localparam logic [3:0]  GAP8_MIN   = 4'hB;
  localparam logic [3:0]  GAP_MAX    = 4'hF;
  // channel codes of the touch measurements
  localparam logic [2:0]  CH_Y       = 3'h1;
  localparam logic [2:0]  CH_Z1      = 3'h3;
  localparam logic [2:0]  CH_Z2      = 3'h4;
  localparam logic [2:0]  CH_X       = 3'h5;
  // reset values
  localparam logic [2:0]  PIN_RST    = 3'h1;
  localparam logic [2:0]  CHAN_RST   = 3'h0;
  localparam logic [1:0]  PD_RST     = 2'h0;
  localparam logic        REF_RST    = 1'b1;
  localparam logic        RES_RST    = 1'b0;
  localparam logic        PEN_RST    = 1'b1;
  // command log buffer
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_CMD  = 2'b10
  } tcd_state_t;

  function automatic logic tcd_is_touch(input logic [2:0] ch);
    return (ch == CH_X) || (ch == CH_Y) || (ch == CH_Z1) || (ch == CH_Z2);
  endfunction

  function automatic logic [3:0] tcd_gap_min(input logic res8);
    return res8 ? GAP8_MIN : GAP12_MIN;
  endfunction
endpackage

// ===== tcd_fifo.sv
`timescale 1ns/1ps
module tcd_fifo #(
  parameter int unsigned WIDTH = tcd_pkg::CMD_W,
  parameter int unsigned DEPTH = tcd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  logic             mclk,
  input  logic             rst_n,
  // filling side
  input  logic             in_valid,
  input  logic [WIDTH-1:0] in_data,
  output logic             in_ready,
  // draining side
  output logic             out_valid,
  output logic [WIDTH-1:0] out_data,
  input  logic             out_ready
);
  import tcd_pkg::*;

  localparam int unsigned   AW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned   CW       = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  // wrap explicitly so depths other than powers of two work
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule // tcd_fifo

// ===== tcd_decoder.sv
`timescale 1ns/1ps
module tcd_decoder #(
  parameter int unsigned FIFO_DEPTH = tcd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  logic                              mclk,
  input  logic                              rst_n,
  // serial link pins
  input  logic                              cs_n,
  input  logic                              serial_clock,
  input  logic                              serial_in,
  output logic                              serial_out,
  output logic                              serial_out_oe,
  output logic                              busy,
  output logic                              busy_oe,
  // converter and analog front end
  input  logic [tcd_pkg::RES12_BITS-1:0]    adc_result,
  output logic                              sample_acquire,
  output logic                              sample_hold,
  output logic [tcd_pkg::CHAN_HI-tcd_pkg::CHAN_LO:0] mux_channel,
  output logic                              ref_single_ended,
  output logic                              res_8bit,
  output logic                              adc_power_on,
  output logic                              ref_power_on,
  output logic                              driver1_on,
  output logic                              driver2_on,
  output logic                              yminus_on,
  output logic                              pen_touch_irq_en,
  // command log
  output logic                              cmd_valid,
  output logic [tcd_pkg::CMD_W-1:0]         cmd_data,
  input  logic                              cmd_ready
);
  import tcd_pkg::*;

  // pin synchronisers, order {serial_in, serial_clock, cs_n}
  logic [2:0]       pin_s1_ff;
  logic [2:0]       pin_s2_ff;
  logic             sclk_d_ff;
  // receiver
  tcd_state_t       state_ff;
  tcd_state_t       nxt_state;
  logic [2:0]       rx_cnt_ff;
  logic [5:0]       shift_ff;
  logic [3:0]       gap_cnt_ff;
  logic [3:0]       nxt_gap_cnt;
  // decoded command
  logic [2:0]       chan_ff;
  logic             ref_single_ff;
  logic             res_8bit_ff;
  logic [1:0]       pd_ff;
  logic             ref_on_ff;
  // conversion phases
  logic             acq_ff;
  logic             conv_ff;
  logic             byte_done_ff;
  logic             busy_ff;
  logic             pen_en_ff;
  logic             drv_hold_ff;
  // result shifter
  logic [11:0]      out_sr_ff;
  logic [3:0]       out_cnt_ff;
  logic             serial_out_ff;
  logic             fifo_in_ready;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_ff <= PIN_RST;
      pin_s2_ff <= PIN_RST;
      sclk_d_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {serial_in, serial_clock, cs_n};
      pin_s2_ff <= pin_s1_ff;
      sclk_d_ff <= pin_s2_ff[1];
    end
  end

  // edges of the link clock, seen only while selected
  wire cs_act = ~pin_s2_ff[0];
  wire din    = pin_s2_ff[2];
  wire rise   = cs_act && pin_s2_ff[1] && !sclk_d_ff;
  wire fall   = cs_act && !pin_s2_ff[1] && sclk_d_ff;

  wire gap_ok     = (gap_cnt_ff >= tcd_gap_min(res_8bit_ff));
  wire start_take = (state_ff == ST_HUNT) && rise && din && gap_ok && fifo_in_ready;
  wire bit_take   = (state_ff == ST_CMD) && rise;
  wire acq_take   = bit_take && (rx_cnt_ff == RX_ACQ_IDX);
  wire last_take  = bit_take && (rx_cnt_ff == RX_LAST_IDX);
  wire [CMD_W-1:0] cmd_byte = {1'b1, shift_ff, din};
  wire hold_take  = fall && byte_done_ff;
  wire out_take   = fall && !hold_take && (out_cnt_ff != 4'h0);
  wire conv_end   = out_take && (out_cnt_ff == 4'h1);
  wire touch_ch   = tcd_is_touch(chan_ff);

  assign nxt_state = !cs_act    ? ST_HUNT :
                     start_take ? ST_CMD  :
                     last_take  ? ST_HUNT : state_ff;
  // the start rise itself counts as the first clock of the spacing
  assign nxt_gap_cnt = !cs_act ? GAP_MAX :
                       start_take ? 4'h1 :
                       (rise && gap_cnt_ff != GAP_MAX) ? gap_cnt_ff + 4'h1 : gap_cnt_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff   <= ST_HUNT;
      gap_cnt_ff <= GAP_MAX;
      rx_cnt_ff  <= 3'h0;
      shift_ff   <= 6'h00;
    end else begin
      state_ff   <= nxt_state;
      gap_cnt_ff <= nxt_gap_cnt;
      if (start_take) begin
        rx_cnt_ff <= 3'h0;
      end else if (bit_take) begin
        rx_cnt_ff <= rx_cnt_ff + 3'h1;
        shift_ff  <= {shift_ff[4:0], din};
      end
    end
  end

  // mux and reference routing is known once the reference bit arrives
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chan_ff       <= CHAN_RST;
      ref_single_ff <= REF_RST;
      res_8bit_ff   <= RES_RST;
      pd_ff         <= PD_RST;
    end else if (acq_take) begin
      chan_ff       <= shift_ff[3:1];
      ref_single_ff <= din;
    end else if (last_take) begin
      res_8bit_ff   <= cmd_byte[MODE_BIT];
      pd_ff         <= cmd_byte[PD_HI:PD_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acq_ff       <= 1'b0;
      conv_ff      <= 1'b0;
      byte_done_ff <= 1'b0;
      busy_ff      <= 1'b0;
    end else if (!cs_act) begin
      acq_ff       <= 1'b0;
      conv_ff      <= 1'b0;
      byte_done_ff <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      acq_ff       <= acq_take || (acq_ff && !hold_take);
      conv_ff      <= hold_take || (conv_ff && !conv_end);
      byte_done_ff <= last_take || (byte_done_ff && !hold_take);
      busy_ff      <= hold_take || (busy_ff && !fall);
    end
  end

  // reference power only follows the command when busy rises
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_on_ff <= 1'b0;
    end else if (hold_take) begin
      ref_on_ff <= pd_ff[PD_HI];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pen_en_ff   <= PEN_RST;
      drv_hold_ff <= 1'b0;
    end else if (!cs_act) begin
      pen_en_ff   <= !pd_ff[PD_LO];
      drv_hold_ff <= 1'b0;
    end else if (acq_take) begin
      pen_en_ff   <= 1'b0;
      drv_hold_ff <= 1'b0;
    end else if (conv_end) begin
      pen_en_ff   <= !pd_ff[PD_LO];
      drv_hold_ff <= pd_ff[PD_LO] && touch_ch && !ref_single_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !cs_act) begin
      out_sr_ff     <= 12'h000;
      out_cnt_ff    <= 4'h0;
      serial_out_ff <= 1'b0;
    end else if (hold_take) begin
      out_sr_ff     <= res_8bit_ff ? {adc_result[11:4], 4'h0} : adc_result;
      out_cnt_ff    <= res_8bit_ff ? RES8_CNT : RES12_CNT;
      serial_out_ff <= 1'b0;
    end else if (out_take) begin
      serial_out_ff <= out_sr_ff[11];
      out_sr_ff     <= {out_sr_ff[10:0], 1'b0};
      out_cnt_ff    <= out_cnt_ff - 4'h1;
    end else if (fall) begin
      serial_out_ff <= 1'b0;
    end
  end

  tcd_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (last_take),
    .in_data   (cmd_byte),
    .in_ready  (fifo_in_ready),
    .out_valid (cmd_valid),
    .out_data  (cmd_data),
    .out_ready (cmd_ready)
  );

  // drivers stay on through conversion only for ratiometric measurement
  wire drv_live = touch_ch && (acq_ff || (conv_ff && !ref_single_ff) || drv_hold_ff);

  assign serial_out       = serial_out_ff;
  assign serial_out_oe    = cs_act;
  assign busy             = busy_ff;
  assign busy_oe          = cs_act;
  assign sample_acquire   = acq_ff;
  assign sample_hold      = conv_ff;
  assign mux_channel      = chan_ff;
  assign ref_single_ended = ref_single_ff;
  assign res_8bit         = res_8bit_ff;
  assign adc_power_on     = pd_ff[PD_LO] || acq_ff || conv_ff;
  assign ref_power_on     = ref_on_ff;
  assign driver1_on       = drv_live && (chan_ff != CH_X);
  assign driver2_on       = drv_live && (chan_ff == CH_X);
  assign yminus_on        = !pd_ff[PD_LO] && !acq_ff && !conv_ff;
  assign pen_touch_irq_en = pen_en_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_start_hunt: assert property (
    (state_ff == ST_HUNT && rise && !din && cs_act) |=> state_ff == ST_HUNT
  ) else $error("low bit opened a command");

  a_field_map: assert property (
    last_take |=> pd_ff == $past(cmd_byte[PD_HI:PD_LO]) && res_8bit_ff == $past(cmd_byte[MODE_BIT])
  ) else $error("command fields misplaced");

  a_restart_gap: assert property (
    start_take |-> gap_cnt_ff >= (res_8bit_ff ? 4'hB : 4'hF)
  ) else $error("command restarted too early");

  a_result_len: assert property (
    hold_take |=> out_cnt_ff == (res_8bit_ff ? 4'h8 : 4'hC)
  ) else $error("result length wrong");

  a_single_drv: assert property (
    (conv_ff && ref_single_ff && !acq_ff && !drv_hold_ff) |-> !driver1_on && !driver2_on
  ) else $error("drivers on in single-ended conversion");

  a_chan_stable: assert property (
    (conv_ff && $past(conv_ff) && !$past(acq_take)) |-> $stable(chan_ff)
  ) else $error("channel changed during conversion");

  a_pen_disabled: assert property (
    (pd_ff[PD_LO] && !acq_ff && !conv_ff) |-> !pen_en_ff
  ) else $error("pen interrupt enabled with power bit 0 set");

  a_ref_latch: assert property (
    hold_take |=> ref_on_ff == $past(pd_ff[PD_HI]) && busy_ff
  ) else $error("reference state not taken at busy");

  a_ref_steady: assert property (
    !$past(hold_take) |-> $stable(ref_on_ff)
  ) else $error("reference state changed outside busy rise");

  a_adc_power: assert property (
    (acq_ff || conv_ff) |-> adc_power_on
  ) else $error("adc off while converting");

  a_hold_order: assert property (
    last_take |-> acq_ff ##1 byte_done_ff
  ) else $error("acquire not open when byte completes");

  a_drv_pair: assert property (
    !(driver1_on && driver2_on) && (!yminus_on || !pd_ff[PD_LO])
  ) else $error("driver combination illegal");

  a_pen_reenable: assert property (
    (conv_end && !pd_ff[PD_LO]) |=> pen_en_ff && !conv_ff
  ) else $error("pen interrupt not re-enabled");

  a_msb_first: assert property (
    out_take |=> serial_out_ff == $past(out_sr_ff[11])
  ) else $error("result bit order wrong");

  a_zero_fill: assert property (
    (fall && out_cnt_ff == 4'h0) |=> !serial_out_ff
  ) else $error("tail not zero filled");

  a_cs_abort: assert property (
    !cs_act |=> state_ff == ST_HUNT && !busy_ff && !acq_ff && !drv_hold_ff
  ) else $error("chip select high did not abort");

  c_conv12: cover property (conv_end && !res_8bit_ff);
  c_conv8: cover property (conv_end && res_8bit_ff);
  c_overlap: cover property (start_take && conv_ff);
  c_abort: cover property (state_ff == ST_CMD && !cs_act);
endmodule // tcd_decoder

// ===== tcd_host.sv
`timescale 1ns/1ps
module tcd_host (
  // clock
  input  logic mclk,
  // link pins
  output logic cs_n,
  output logic serial_clock,
  output logic serial_in,
  input  logic serial_out,
  input  logic busy
);
  initial begin
    cs_n         = 1'h1;
    serial_clock = 1'h0;
    serial_in    = 1'h0;
  end

  // select or deselect, then leave setup time before any clock edge
  task automatic sel(input logic v);
    @(negedge mclk);
    cs_n = v;
    repeat (4) @(negedge mclk);
  endtask

  // one serial clock of 8 mclk; answers are taken just before the rise
  task automatic cyc(input logic d, output logic so, output logic bz);
    @(negedge mclk);
    serial_in = d;
    repeat (3) @(negedge mclk);
    so           = serial_out;
    bz           = busy;
    serial_clock = 1'h1;
    repeat (4) @(negedge mclk);
    serial_clock = 1'h0;
    // hold time is over: show a stale bit inverted
    serial_in    = ~serial_in;
  endtask
endmodule // tcd_host

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import tcd_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [11:0] adc;
  logic        cmd_ready;
  logic        cs_n;
  logic        serial_clock;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        busy;
  logic        busy_oe;
  logic        sample_acquire;
  logic        sample_hold;
  logic [2:0]  mux_channel;
  logic        ref_single_ended;
  logic        res_8bit;
  logic        adc_power_on;
  logic        ref_power_on;
  logic        driver1_on;
  logic        driver2_on;
  logic        yminus_on;
  logic        pen_touch_irq_en;
  logic        cmd_valid;
  logic [7:0]  cmd_data;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [15:0] lf = 16'h0061;
  logic [7:0]  q[$];
  logic        pref = 1'h0;

  tcd_decoder dut (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .busy(busy), .busy_oe(busy_oe), .adc_result(adc), .sample_acquire(sample_acquire),
    .sample_hold(sample_hold), .mux_channel(mux_channel), .ref_single_ended(ref_single_ended),
    .res_8bit(res_8bit), .adc_power_on(adc_power_on), .ref_power_on(ref_power_on),
    .driver1_on(driver1_on), .driver2_on(driver2_on), .yminus_on(yminus_on),
    .pen_touch_irq_en(pen_touch_irq_en), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready)
  );

  tcd_host host (
    .mclk(mclk), .cs_n(cs_n), .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .busy(busy)
  );

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [15:0] nxt_rand();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one selected frame: lead zeros, then n clocks counted from the command start bit; s2 places a second start bit
  task automatic frame(input logic [7:0] c, input int lead, input int n, input int s2);
    logic        so, bz, d, acc, d1e, d2e;
    logic [11:0] r;
    int          k, nb;
    nb  = c[3] ? 8 : 12;
    r   = c[3] ? {4'h0, adc[11:4]} : adc;
    acc = q.size() < 16;
    d1e = ~c[2] & (c[6:4] != CH_X);
    d2e = ~c[2] & (c[6:4] == CH_X);
    host.sel(1'h0);
    for (k = 1 - lead; k <= n; k++) begin
      d = (k >= 1 && k <= 8) ? c[8-k] : (s2 > 0 && k == s2);
      host.cyc(d, so, bz);
      chk(bz, acc && k == 9);
      if (acc && k >= 10)
        chk(so, (k <= 9 + nb) ? r[nb+9-k] : 1'h0);
      if (acc && k == 8)
        chk(ref_power_on, pref);
      if (acc && k == 9) begin
        chk({mux_channel, ref_single_ended, res_8bit, ref_power_on, adc_power_on},
            {c[6:4], c[2], c[3], c[1], 1'h1});
        chk({pen_touch_irq_en, sample_hold, sample_acquire, serial_out_oe, busy_oe},
            5'h0B);
        chk({driver1_on, driver2_on}, {d1e, d2e});
      end
      if (s2 > 0 && k == s2 + 5)
        chk(sample_acquire, s2 >= (c[3] ? 12 : 16));
      if (acc && s2 == 0 && k == 8 + nb)
        chk(pen_touch_irq_en, 1'h0);
      if (acc && s2 == 0 && k == 9 + nb)
        chk({pen_touch_irq_en, adc_power_on, yminus_on, driver1_on, driver2_on, sample_hold},
            {~c[0], c[0], ~c[0], d1e & c[0], d2e & c[0], 1'h0});
    end
    host.sel(1'h1);
    if (acc && n >= 8) begin
      q.push_back(c);
      pref = c[1];
      if (s2 == 0)
        chk({driver1_on, driver2_on}, 2'h0);
    end
  endtask

  // pop the command log with random stalls
  task automatic drain();
    logic [15:0] rv;
    int          i;
    for (i = 0; i < 400 && q.size() > 0; i++) begin
      rv = nxt_rand();
      if (rv[0] && cmd_valid === 1'h1)
        chk(cmd_data, q.pop_front());
      cmd_ready = rv[0];
      @(negedge mclk);
    end
    cmd_ready = 1'h0;
    if (q.size() > 0) begin
      error_cnt++;
      $display("Error at %0t: command log did not drain", $time);
      finish_test();
    end
    @(negedge mclk);
    chk(cmd_valid, 1'h0);
  endtask

  initial begin
    logic [15:0] rv;
    logic [15:0] rw;
    logic [7:0]  c;
    logic        tch;
    int          i, j;
    rst_n     = 1'h0;
    cmd_ready = 1'h0;
    adc       = 12'h000;
    repeat (3) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
    chk({mux_channel, ref_single_ended, res_8bit, ref_power_on, pen_touch_irq_en, busy, cmd_valid},
        {CHAN_RST, REF_RST, RES_RST, 1'h0, PEN_RST, 2'h0});
    // sixteen fill the log, the seventeenth is held off
    for (i = 0; i < 17; i++) begin
      rv  = nxt_rand();
      tch = rv[2:0] inside {CH_Y, CH_Z1, CH_Z2, CH_X};
      c   = {1'h1, rv[2:0], rv[3], tch ? rv[4] : 1'h1, i[1:0]};
      rw  = nxt_rand();
      adc = rv[15:4] ^ rw[11:0];
      // power codes cycle, so a later command drops the reference; 0 to 3 lead clocks of zeros come before the start bit
      frame(c, rv[6:5], 24, 0);
    end
    $display("test decode done");
    drain();
    $display("test drain done");
    frame(8'hD5, 0, 5, 0);
    for (i = 0; i < 2; i++) begin
      for (j = 0; j < 2; j++) begin
        c = {1'h1, CH_X, i[0], 1'h0, 2'h1};
        frame(c, 0, (i ? 11 : 15) + j + 6, (i ? 11 : 15) + j);
      end
    end
    drain();
    $display("test spacing and abort done");
    finish_test();
  end
endmodule // testbench
